// ### rtl/ddr_sdram_burst_access_core.sv
`timescale 1ns/100ps
// How it works
// R1: commands, address, bank sampled at true clock rise; data with strobes
// R2: read words leave on every rise and every fall of the clock
// R3: bursts start at given column and walk the programmed count
// R4: controller opens a row before reading or writing that bank
// R5: burst length 2, 4 or 8 from mode register, exactly that many
// R6: auto precharge closes the row when the burst finishes
// R7: read latency 2, 2.5 or 3 clocks, programmable
// R8: sequential or interleaved column order chosen by mode register
// R9: four banks of 4096 rows by 256 columns of 32 bits
// R10: controller refreshes 4096 rows every 64 ms
// R11: auto refresh steps a row counter; self refresh runs its own timer
// R12: write masks block their byte on writes, ignored on reads
// R13: one two-way strobe per byte, both edges carry data
// R14: read strobe edges coincide with data changes
// R15: row strobe low, column high: open row or precharge by write enable
// R16: row high, column low: read or write by write enable
// R17: bit 8 auto or all-bank precharge; column bits 0-7, row bits 0-11
// R18: chip select high ignores commands; clock enable low freezes read bursts and the array drain
// R19: no-operation leaves any running burst untouched

module beat_fifo #(
  parameter int WIDTH = 58,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = buf_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      buf_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : beat_fifo

module ddr_sdram_burst_access_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic diff_clock_true,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [11:0] addr,
  input wire logic [3:0] byte_write_mask,
  input wire logic [31:0] dq_i,
  output logic [31:0] dq_o,
  output logic dq_oe,
  input wire logic [3:0] dqs_i,
  output logic [3:0] dqs_o,
  output logic dqs_oe,
  output logic [3:0] bank_open,
  output logic self_refresh,
  output logic [11:0] refresh_row,
  output logic write_stall
);
  localparam int PIN_W = 60;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  ddr_pkg::cmd_t cmd;
  logic [3:0] dm;
  logic [31:0] dq;
  logic [3:0] dqs;
  logic [1:0] ba;
  logic ck_q, run_q, ck_rise, ck_edge, cmd_ok;
  logic is_act, is_pre, is_rd, is_wr, is_ref, is_mrs;
  logic [11:0] mode_q;
  logic [2:0] bl_code, cl_code;
  logic bt;
  logic [3:0] open_q;
  logic [11:0] row_q [4];
  logic [31:0] mem [2**22];
  logic [2:0] rd_wait_q, rd_idx_q;
  logic [3:0] rd_left_q;
  logic [21:0] rd_base_q, rd_addr;
  logic rd_ap_q, rd_beat_q, rd_emit, rd_close;
  logic [3:0] wr_left_q, dqs_q, lane_m_q, lane_edge;
  logic [2:0] wr_idx_q;
  logic [21:0] wr_base_q;
  logic [31:0] lane_d_q;
  logic wr_ap_q, beat_q, accept, wr_close, fifo_ready, w_valid;
  ddr_pkg::wbeat_t w_in, w_out;
  logic [9:0] sr_cnt_q;

  function automatic logic [3:0] bl_words(input logic [2:0] c);
    return (c == ddr_pkg::BL_8) ? 4'h8 : (c == ddr_pkg::BL_4) ? 4'h4 : 4'h2;
  endfunction : bl_words

  function automatic logic [2:0] lat_halves(input logic [2:0] c);
    return (c == ddr_pkg::CL_3) ? 3'h6 : (c == ddr_pkg::CL_25) ? 3'h5 : 3'h4;
  endfunction : lat_halves

  function automatic logic [7:0] burst_col(input logic [7:0] s,
    input logic [2:0] i, input logic [2:0] c, input logic il);
    logic [2:0] m;
    logic [2:0] o;
    m = (c == ddr_pkg::BL_8) ? 3'h7 : (c == ddr_pkg::BL_4) ? 3'h3 : 3'h1;
    o = il ? (s[2:0] ^ i) : (s[2:0] + i);
    return {s[7:3], (s[2:0] & ~m) | (o & m)};
  endfunction : burst_col

  // every pin, link clock included, is retimed twice before use
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= {diff_clock_true, cke, cs_n, ras_n, cas_n, we_n,
        bank_select_bit1, bank_select_bit0, addr, byte_write_mask,
        dq_i, dqs_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign cmd = ddr_pkg::cmd_t'(pin_s2_q[58:40]);
  assign dm = pin_s2_q[39:36];
  assign dq = pin_s2_q[35:4];
  assign dqs = pin_s2_q[3:0];
  assign ba = cmd.ba;
  assign ck_rise = pin_s2_q[59] && !ck_q;
  assign ck_edge = (pin_s2_q[59] != ck_q) && run_q;
  assign cmd_ok = ck_rise && run_q && !cmd.cs_n; // see R1 see R18
  assign is_act = cmd_ok && !cmd.ras_n && cmd.cas_n && cmd.we_n; // see R15
  assign is_pre = cmd_ok && !cmd.ras_n && cmd.cas_n && !cmd.we_n; // see R15
  // access to a closed bank is dropped; see R4 see R16
  assign is_rd = cmd_ok && cmd.ras_n && !cmd.cas_n && cmd.we_n && open_q[ba];
  assign is_wr = cmd_ok && cmd.ras_n && !cmd.cas_n && !cmd.we_n && open_q[ba];
  assign is_ref = cmd_ok && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
  assign is_mrs = cmd_ok && !cmd.ras_n && !cmd.cas_n && !cmd.we_n &&
    ba == 2'h0;
  assign bl_code = mode_q[ddr_pkg::MODE_BL_LSB +: 3]; // see R5
  assign cl_code = mode_q[ddr_pkg::MODE_CL_LSB +: 3]; // see R7
  assign bt = mode_q[ddr_pkg::MODE_BT_BIT]; // see R8

  // clock enable takes hold from the edge after it is sampled low
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ck_q <= 1'b0;
      run_q <= 1'b1;
    end
    else
    begin
      ck_q <= pin_s2_q[59];
      if (ck_rise)
      begin
        run_q <= cmd.cke; // see R18
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_q <= ddr_pkg::MODE_RST;
    end
    else if (is_mrs)
    begin
      mode_q <= cmd.addr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (is_act)
    begin
      row_q[ba] <= cmd.addr; // see R17
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      open_q <= '0;
    end
    else
    begin
      if (is_act)
      begin
        open_q[ba] <= 1'b1; // see R15
      end
      if (is_pre && cmd.addr[ddr_pkg::AP_BIT])
      begin
        open_q <= '0; // see R17
      end
      else if (is_pre)
      begin
        open_q[ba] <= 1'b0;
      end
      if (rd_close)
      begin
        open_q[rd_base_q[21:20]] <= 1'b0; // see R6
      end
      if (wr_close)
      begin
        open_q[wr_base_q[21:20]] <= 1'b0; // see R6
      end
    end
  end

  // a new read restarts the engine; a no-operation leaves it running
  assign rd_emit = ck_edge && !is_rd && (rd_wait_q == 3'h1 ||
    (rd_wait_q == 3'h0 && rd_left_q != 4'h0)); // see R2 see R19
  assign rd_addr = {rd_base_q[21:8],
    burst_col(rd_base_q[7:0], rd_idx_q, bl_code, bt)}; // see R3 see R8
  assign rd_close = rd_emit && rd_left_q == 4'h1 && rd_ap_q; // see R6

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_wait_q <= '0;
      rd_left_q <= '0;
      rd_idx_q <= '0;
      rd_base_q <= '0;
      rd_ap_q <= 1'b0;
    end
    else if (is_rd)
    begin
      rd_wait_q <= lat_halves(cl_code); // see R7
      rd_left_q <= bl_words(bl_code); // see R5
      rd_idx_q <= '0;
      rd_base_q <= {ba, row_q[ba], cmd.addr[7:0]}; // see R9 see R17
      rd_ap_q <= cmd.addr[ddr_pkg::AP_BIT];
    end
    else if (ck_edge)
    begin
      if (rd_wait_q != 3'h0)
      begin
        rd_wait_q <= rd_wait_q - 3'h1;
      end
      if (rd_emit)
      begin
        rd_left_q <= rd_left_q - 4'h1;
        rd_idx_q <= rd_idx_q + 3'h1;
      end
    end
  end

  // strobe toggles with each word, so its edges sit on data changes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dq_o <= '0;
      dq_oe <= 1'b0;
      dqs_o <= '0;
      dqs_oe <= 1'b0;
      rd_beat_q <= 1'b0;
    end
    else
    begin
      rd_beat_q <= rd_emit;
      if (rd_emit)
      begin
        dq_o <= mem[rd_addr]; // see R2 see R12
        dqs_o <= {4{~rd_idx_q[0]}}; // see R13 see R14
        dq_oe <= 1'b1;
        dqs_oe <= 1'b1;
      end
      else if (ck_edge && rd_wait_q == 3'h0 && rd_left_q == 4'h0)
      begin
        dq_oe <= 1'b0;
        dqs_oe <= 1'b0;
        dqs_o <= '0;
      end
    end
  end

  // each byte lane is caught on either edge of its own strobe
  assign lane_edge = (dqs ^ dqs_q) & {4{wr_left_q != 4'h0}}; // see R13
  assign accept = beat_q && fifo_ready;
  assign wr_close = accept && wr_left_q == 4'h1 && wr_ap_q; // see R6
  assign w_in = '{addr: {wr_base_q[21:8],
    burst_col(wr_base_q[7:0], wr_idx_q, bl_code, bt)}, // see R3
    data: lane_d_q, mask: lane_m_q};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dqs_q <= '0;
      lane_d_q <= '0;
      lane_m_q <= '0;
      beat_q <= 1'b0;
    end
    else
    begin
      dqs_q <= dqs;
      for (int l = 0; l < 4; l++)
      begin
        if (lane_edge[l])
        begin
          lane_d_q[8*l +: 8] <= dq[8*l +: 8]; // see R1 see R13
          lane_m_q[l] <= dm[l]; // see R12
        end
      end
      // lane 0 paces the beat; a stalled beat is held until taken or until the next strobe edge replaces it
      if (lane_edge[0])
      begin
        beat_q <= 1'b1;
      end
      else if (accept)
      begin
        beat_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_left_q <= '0;
      wr_idx_q <= '0;
      wr_base_q <= '0;
      wr_ap_q <= 1'b0;
      write_stall <= 1'b0;
    end
    else
    begin
      write_stall <= beat_q && !fifo_ready;
      if (is_wr)
      begin
        wr_left_q <= bl_words(bl_code); // see R5
        wr_idx_q <= '0;
        wr_base_q <= {ba, row_q[ba], cmd.addr[7:0]}; // see R9
        wr_ap_q <= cmd.addr[ddr_pkg::AP_BIT];
      end
      else if (accept)
      begin
        wr_left_q <= wr_left_q - 4'h1;
        wr_idx_q <= wr_idx_q + 3'h1;
      end
    end
  end

  // the array drain pauses while the clock is suspended
  beat_fifo #(
    .WIDTH($bits(ddr_pkg::wbeat_t)),
    .DEPTH(ddr_pkg::FIFO_DEPTH)
  ) u_wfifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(w_in),
    .in_valid(beat_q),
    .in_ready(fifo_ready),
    .out_data(w_out),
    .out_valid(w_valid),
    .out_ready(run_q)
  );

  always_ff @(posedge clk)
  begin
    if (w_valid && run_q)
    begin
      for (int l = 0; l < 4; l++)
      begin
        if (!w_out.mask[l])
        begin
          mem[w_out.addr][8*l +: 8] <= w_out.data[8*l +: 8]; // see R12
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      refresh_row <= ddr_pkg::ROW_RST;
      self_refresh <= 1'b0;
      sr_cnt_q <= '0;
    end
    else
    begin
      if (is_ref && !cmd.cke)
      begin
        self_refresh <= 1'b1; // see R11
      end
      else if (self_refresh && ck_rise && cmd.cke)
      begin
        self_refresh <= 1'b0;
      end
      if (self_refresh)
      begin
        sr_cnt_q <= sr_cnt_q + 10'h001;
        if (sr_cnt_q == 10'(ddr_pkg::REFRESH_CYC - 1))
        begin
          sr_cnt_q <= '0;
          refresh_row <= refresh_row + 12'h001; // see R11
        end
      end
      else if (is_ref)
      begin
        refresh_row <= refresh_row + 12'h001; // see R10 see R11
      end
    end
  end

  assign bank_open = open_q;

  logic [2:0] lat_cnt_q, gap_q;
  logic [3:0] beats_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst || is_rd)
    begin
      lat_cnt_q <= '0;
      beats_q <= '0;
      gap_q <= '0;
    end
    else
    begin
      if (ck_edge && lat_cnt_q != 3'h7 && beats_q == 4'h0)
      begin
        lat_cnt_q <= lat_cnt_q + 3'h1;
      end
      beats_q <= beats_q + 4'(rd_emit);
      gap_q <= rd_emit ? 3'h0 : gap_q + 3'(ck_edge && gap_q != 3'h7);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rd_last;
    rd_emit && rd_left_q == 4'h1 && rd_ap_q;
  endsequence
  sequence s_cs_idle;
    ck_rise && cmd.cs_n && !rd_close && !wr_close;
  endsequence

  chk_bank_cmd_edge: assert property ( // see R1
    $changed(open_q) && !$past(rd_close) && !$past(wr_close)
    |-> $past(ck_rise && !cmd.cs_n))
    else $error("bank state changed without a sampled command");
  chk_cs_masks_cmd: assert property ( // see R18
    s_cs_idle |=> $stable(open_q) && $stable(mode_q))
    else $error("command taken while chip select high");
  chk_suspend_hold: assert property ( // see R18
    !run_q && $past(!run_q) |-> $stable(dq_o) && $stable(dq_oe))
    else $error("read output moved while clock suspended");
  chk_double_rate: assert property ( // see R2
    rd_emit && rd_wait_q == 3'h0 |-> gap_q == 3'h0)
    else $error("read word skipped a clock edge");
  chk_strobe_toggle: assert property ( // see R14
    rd_beat_q |-> dqs_oe && dqs_o == ~$past(dqs_o))
    else $error("read strobe did not toggle with data");
  chk_read_latency: assert property ( // see R7
    $rose(dq_oe) |-> lat_cnt_q == lat_halves(cl_code))
    else $error("first read word at wrong latency");
  chk_burst_len: assert property ( // see R5
    $fell(dq_oe) |-> beats_q == bl_words(bl_code))
    else $error("read burst word count wrong");
  chk_auto_pre: assert property ( // see R6
    s_rd_last ##1 !is_act |-> !open_q[$past(rd_base_q[21:20])])
    else $error("auto precharge left row open");
  chk_mask_holds: assert property ( // see R12
    w_valid && run_q && w_out.mask == 4'hF
    |=> mem[$past(w_out.addr)] == $past(mem[w_out.addr]))
    else $error("masked write changed memory");
  chk_nop_keeps: assert property ( // see R19
    rd_left_q != 4'h0 && cmd_ok && cmd.ras_n && cmd.cas_n && cmd.we_n
    |=> rd_left_q != 4'h0 || $past(rd_emit))
    else $error("no-operation disturbed a read burst");
endmodule : ddr_sdram_burst_access_core

// ### rtl/ddr_pkg.sv
package ddr_pkg;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int AP_BIT = 8;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [2:0] CL_25 = 3'h6;
  localparam logic [11:0] MODE_RST = 12'h022;
  localparam logic [11:0] ROW_RST = 12'h000;
  localparam int REFRESH_MS = 64;
  localparam int REFRESH_ROWS = 4096;
  localparam int CLK_KHZ = 40000;
  // longest spacing between self refreshes, rounded down
  localparam int REFRESH_CYC = CLK_KHZ * REFRESH_MS / REFRESH_ROWS;
  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ROW_W-1:0] addr;
  } cmd_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [31:0] data;
    logic [3:0] mask;
  } wbeat_t;
endpackage : ddr_pkg

// ### dv/ddr_ctrl_model.sv
`timescale 1ns/100ps
module ddr_ctrl_model (
  input wire logic clk,
  output logic ck,
  output ddr_pkg::cmd_t cmd,
  output logic [3:0] mask,
  output logic [31:0] dq,
  output logic [3:0] dqs
);
  // link clock runs free, phase offset from clk so edges never coincide
  initial
  begin
    ck = 1'b0;
    cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 12'h000};
    mask = 4'h0;
    dq = 32'h0000_0000;
    dqs = 4'h0;
    #7;
    forever #100 ck = ~ck;
  end

  // pins set near the fall, held past the rise, deselected before the next
  task automatic cmd_go(
    input logic [2:0] rcw,
    input logic [1:0] b,
    input logic [11:0] a,
    input logic csn,
    input logic ke
  );
    @(negedge ck);
    @(posedge clk);
    #1;
    cmd.cke = ke;
    cmd.cs_n = csn;
    {cmd.ras_n, cmd.cas_n, cmd.we_n} = rcw;
    cmd.ba = b;
    cmd.addr = a;
    @(posedge ck);
    repeat (4) @(posedge clk);
    #1;
    cmd.cs_n = 1'b1;
  endtask : cmd_go

  task automatic set_cke(input logic ke);
    @(posedge clk);
    #1;
    cmd.cke = ke;
  endtask : set_cke

  // data leads each strobe edge by 50 ns and holds 50 ns after it
  task automatic wburst(
    input int n,
    input logic [255:0] d,
    input logic [31:0] m
  );
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      #1;
      dq = d[i*32 +: 32];
      mask = m[i*4 +: 4];
      repeat (2) @(posedge clk);
      #1;
      dqs = ~dqs;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    #1;
    // released lines must not keep showing the last beat
    dq = ~dq;
    mask = ~mask;
  endtask : wburst
endmodule : ddr_ctrl_model

// ### dv/ddr_sdram_burst_access_core_test.sv
`timescale 1ns/100ps
module ddr_sdram_burst_access_core_test;
  logic clk;
  logic sys_rst;
  logic ck;
  ddr_pkg::cmd_t cmd;
  logic [3:0] mask;
  logic [31:0] dq_c;
  logic [3:0] dqs_c;
  logic [31:0] dq_i;
  logic [31:0] dq_o;
  logic [3:0] dqs_i;
  logic [3:0] dqs_o;
  logic dq_oe;
  logic dqs_oe;
  logic [3:0] bank_open;
  logic self_refresh;
  logic [11:0] refresh_row;
  logic write_stall;
  logic saw_stall;
  int n_mismatch;
  int n_checks;
  int w;
  logic [31:0] mem [256];
  logic [2:0] m_bl [3] = '{ddr_pkg::BL_8, ddr_pkg::BL_2, ddr_pkg::BL_4};
  logic [2:0] m_cl [3] = '{ddr_pkg::CL_3, ddr_pkg::CL_25, ddr_pkg::CL_2};
  logic m_il [3] = '{1'b1, 1'b0, 1'b1};
  logic [7:0] m_col [3] = '{8'h05, 8'h07, 8'h06};
  int n_bl [3] = '{8, 2, 4};
  int n_lat [3] = '{6, 5, 4};

  // whoever enables drives the shared lines
  assign dq_i = dq_oe ? dq_o : dq_c;
  assign dqs_i = dqs_oe ? dqs_o : dqs_c;

  ddr_ctrl_model ctl (
    .clk(clk),
    .ck(ck),
    .cmd(cmd),
    .mask(mask),
    .dq(dq_c),
    .dqs(dqs_c)
  );

  ddr_sdram_burst_access_core uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .diff_clock_true(ck),
    .cke(cmd.cke),
    .cs_n(cmd.cs_n),
    .ras_n(cmd.ras_n),
    .cas_n(cmd.cas_n),
    .we_n(cmd.we_n),
    .bank_select_bit0(cmd.ba[0]),
    .bank_select_bit1(cmd.ba[1]),
    .addr(cmd.addr),
    .byte_write_mask(mask),
    .dq_i(dq_i),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dqs_i(dqs_i),
    .dqs_o(dqs_o),
    .dqs_oe(dqs_oe),
    .bank_open(bank_open),
    .self_refresh(self_refresh),
    .refresh_row(refresh_row),
    .write_stall(write_stall)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
    if (sys_rst)
      saw_stall <= 1'b0;
    else if (write_stall === 1'b1)
      saw_stall <= 1'b1;

  task automatic check(
    input string what,
    input logic [31:0] seen,
    input logic [31:0] exp
  );
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task complete_run;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  function automatic logic [255:0] pat(input logic [7:0] t);
    logic [255:0] r;
    for (int i = 0; i < 8; i++)
      r[i*32 +: 32] = {t, 8'(i), ~t, 8'(i)};
    return r;
  endfunction : pat

  function automatic logic [7:0] colmap(
    input logic [7:0] c,
    input int bl,
    input logic il,
    input int k
  );
    logic [7:0] s;
    s = 8'(bl - 1);
    if (il)
      return c ^ 8'(k);
    return (c & ~s) | ((c + 8'(k)) & s);
  endfunction : colmap

  // non-read command, then time for the decode to land
  task automatic op(
    input logic [2:0] rcw,
    input logic [1:0] b,
    input logic [11:0] a,
    input logic csn,
    input logic ke
  );
    ctl.cmd_go(rcw, b, a, csn, ke);
    repeat (3) @(posedge clk);
  endtask : op

  task automatic wr(
    input logic [7:0] c,
    input int bl,
    input logic il,
    input logic [255:0] d,
    input logic [31:0] m
  );
    logic [7:0] a;
    for (int k = 0; k < bl; k++)
    begin
      a = colmap(c, bl, il, k);
      for (int b = 0; b < 4; b++)
        if (!m[k*4+b])
          mem[a][b*8 +: 8] = d[k*32+b*8 +: 8];
    end
    ctl.cmd_go(3'b100, 2'h0, {4'h0, c}, 1'b0, 1'b1);
    ctl.wburst(bl, d, m);
    // no drain-done flag; a few clk per beat is ample
    repeat (20) @(posedge clk);
  endtask : wr

  // samples 4 clk after each link edge: the word has landed one clk
  // before, and the next link edge is still ahead, so none is skipped
  task automatic rd(
    input logic [7:0] c,
    input int bl,
    input int lat,
    input logic il,
    input logic ap,
    input logic en
  );
    logic on;
    ctl.cmd_go(3'b101, 2'h0, {3'h0, ap, c}, 1'b0, 1'b1);
    for (int e = 1; e <= lat + bl; e++)
    begin
      @(ck);
      repeat (4) @(posedge clk);
      #1;
      on = en && e >= lat && e < lat + bl;
      check("read enables", {dq_oe, dqs_oe}, {on, on});
      if (on)
      begin
        check("read word", dq_o, mem[colmap(c, bl, il, e - lat)]);
        check("read strobe", dqs_o, (e - lat) % 2 ? 4'h0 : 4'hF);
      end
    end
  endtask : rd

  initial
  begin
    #100000;
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge clk);
    check("reset outputs", {bank_open, refresh_row, dq_oe, dqs_oe,
      self_refresh, write_stall}, 20'h0_0000);
    rd(8'h00, 4, 4, 1'b0, 1'b0, 1'b0);
    op(3'b011, 2'h0, 12'h005, 1'b1, 1'b1);
    check("deselected open", bank_open, 4'h0);
    op(3'b011, 2'h0, 12'h005, 1'b0, 1'b1);
    check("row open", bank_open, 4'h1);
    wr(8'h00, 4, 1'b0, pat(8'hA0), 32'h0000_0000);
    wr(8'h04, 4, 1'b0, pat(8'hB0), 32'h0000_0000);
    wr(8'h02, 4, 1'b0, pat(8'hC0), 32'h0000_6801);
    rd(8'h01, 4, 4, 1'b0, 1'b0, 1'b1);
    for (int j = 0; j < 3; j++)
    begin
      op(3'b000, 2'h0, {5'h00, m_cl[j], m_il[j], m_bl[j]}, 1'b0,
        1'b1);
      if (j == 0)
        wr(8'h03, 8, 1'b1, pat(8'hD0), 32'h0000_0F00);
      rd(m_col[j], n_bl[j], n_lat[j], m_il[j], 1'b0, 1'b1);
    end
    rd(8'h00, 4, 4, 1'b1, 1'b1, 1'b1);
    check("auto precharge", bank_open, 4'h0);
    op(3'b011, 2'h1, 12'hFFF, 1'b0, 1'b1);
    op(3'b011, 2'h2, 12'h000, 1'b0, 1'b1);
    check("two banks", bank_open, 4'h6);
    op(3'b010, 2'h1, 12'h000, 1'b0, 1'b1);
    check("one precharged", bank_open, 4'h4);
    op(3'b011, 2'h3, 12'h001, 1'b0, 1'b1);
    op(3'b010, 2'h0, 12'h100, 1'b0, 1'b1);
    check("all precharged", bank_open, 4'h0);
    op(3'b001, 2'h0, 12'h000, 1'b0, 1'b1);
    op(3'b001, 2'h0, 12'h000, 1'b0, 1'b1);
    check("refresh row", refresh_row, 12'h002);
    op(3'b001, 2'h0, 12'h000, 1'b0, 1'b0);
    check("self refresh in", self_refresh, 1'b1);
    op(3'b111, 2'h0, 12'h000, 1'b0, 1'b1);
    check("self refresh out", self_refresh, 1'b0);
    op(3'b011, 2'h0, 12'h005, 1'b0, 1'b1);
    op(3'b000, 2'h0, {5'h00, ddr_pkg::CL_2, 1'b0, ddr_pkg::BL_8},
      1'b0, 1'b1);
    check("no early stall", saw_stall, 1'b0);
    // clock held off so the queue cannot drain and must refuse
    ctl.cmd_go(3'b100, 2'h0, 12'h000, 1'b0, 1'b1);
    ctl.set_cke(1'b0);
    ctl.wburst(8, pat(8'hE0), 32'h0000_0000);
    check("queue full stall", saw_stall, 1'b1);
    ctl.set_cke(1'b1);
    for (w = 0; w < 400 && write_stall !== 1'b0; w++)
      @(posedge clk);
    if (w == 400)
    begin
      n_mismatch++;
      complete_run();
    end
    repeat (40) @(posedge clk);
    check("queue drained", write_stall, 1'b0);
    complete_run();
  end
endmodule : ddr_sdram_burst_access_core_test
